// ===== common/ifsb_cfg.svh
// Offsets, bit positions and reset values of the interrupt flag status bank.
`ifndef IFSB_CFG_SVH
`define IFSB_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define IFSB_OFS_FLAGS0      8'h00
`define IFSB_OFS_FLAGS1      8'h04
`define IFSB_OFS_MASK0       8'h08
`define IFSB_OFS_MASK1       8'h0c

// ----------------------------------------------------------------------------
// Flag positions in interrupt_flags_0
// ----------------------------------------------------------------------------
`define IFSB_BIT_EXT_INPUT0  0
`define IFSB_BIT_CAPTURE1    1
`define IFSB_BIT_COMPARE1    2

// ----------------------------------------------------------------------------
// Flag positions in interrupt_flags_1
// ----------------------------------------------------------------------------
`define IFSB_BIT_COMPARE3    9
`define IFSB_BIT_COMPARE4    10
`define IFSB_BIT_TIMER_FOUR  11
`define IFSB_BIT_TIMER_FIVE  12
`define IFSB_BIT_EXT_INPUT2  13
`define IFSB_BIT_SERIAL2_RX  14
`define IFSB_BIT_SERIAL2_TX  15

// ----------------------------------------------------------------------------
// Implemented bits and reset values
// ----------------------------------------------------------------------------
`define IFSB_IMPL0           16'h0007
`define IFSB_IMPL1           16'hfe00
`define IFSB_FLAGS_RST       16'h0000
`define IFSB_MASK_RST        16'h0000

`endif

// ===== common/ifsb_pkg.sv
// Types shared by the interrupt flag status bank.
package ifsb_pkg;

	// ------------------------------------------------------------------------
	// Bus phase tracking
	// ------------------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE      = 4'b0001,
		ST_WRITE     = 4'b0010,
		ST_READ_WAIT = 4'b0100,
		ST_READ_DATA = 4'b1000
	} ifsb_state_t;

	typedef logic [15:0] ifsb_word_t;

endpackage : ifsb_pkg

// ===== logic/ifsb_top.sv
// Interrupt flag status bank with an AHB-Lite register slave and interrupt output.

`include "ifsb_cfg.svh"

module ifsb_top
	import ifsb_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	input  wire logic              SYS_CLK,
	input  wire logic              RST_N,
	input  wire logic              HSEL,
	input  wire logic [ADDR_W-1:0] HADDR,
	input  wire logic [1:0]        HTRANS,
	input  wire logic              HWRITE,
	input  wire logic [2:0]        HSIZE,
	input  wire logic [31:0]       HWDATA,
	input  wire logic              HREADY,
	output logic      [31:0]       HRDATA,
	output logic                   HREADYOUT,
	output logic                   HRESP,
	input  wire logic              EXT_INPUT0_REQ,
	input  wire logic              CAPTURE1_REQ,
	input  wire logic              COMPARE1_REQ,
	input  wire logic              COMPARE3_REQ,
	input  wire logic              COMPARE4_REQ,
	input  wire logic              TIMER_FOUR_REQ,
	input  wire logic              TIMER_FIVE_REQ,
	input  wire logic              EXT_INPUT2_REQ,
	input  wire logic              SERIAL2_RX_REQ,
	input  wire logic              SERIAL2_TX_REQ,
	output logic                   IRQ
);

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	localparam ifsb_word_t IMPL0 = `IFSB_IMPL0;
	localparam ifsb_word_t IMPL1 = `IFSB_IMPL1;
	localparam ifsb_word_t FLAGS_RST = `IFSB_FLAGS_RST;

	ifsb_state_t state;
	ifsb_state_t next_state;
	logic [7:0]  addr_q;
	logic        take;
	ifsb_word_t  flags0;
	ifsb_word_t  flags1;
	ifsb_word_t  mask0;
	ifsb_word_t  mask1;
	ifsb_word_t  evt0;
	ifsb_word_t  evt1;
	ifsb_word_t  clr0;
	ifsb_word_t  clr1;
	logic        wr_now;
	logic [31:0] next_rdata;

	// ------------------------------------------------------------------------
	// Bus phase tracking
	// ------------------------------------------------------------------------
	// Reads take one wait state so that a read right after a write sees it.
	assign take = HSEL && HTRANS[1] && HREADY;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE, ST_WRITE, ST_READ_DATA: begin
				if (take) begin
					next_state = HWRITE ? ST_WRITE : ST_READ_WAIT;
				end else if (HREADY) begin
					next_state = ST_IDLE;
				end
			end
			ST_READ_WAIT: begin
				next_state = ST_READ_DATA;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			addr_q <= 8'h00;
		end else if (take) begin
			addr_q <= HADDR[7:0];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			HREADYOUT <= 1'b1;
		end else begin
			HREADYOUT <= (next_state != ST_READ_WAIT);
		end
	end

	// Only OKAY responses; unmapped offsets read zero and ignore writes.
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			HRESP <= 1'b0;
		end else begin
			HRESP <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------------------
	// Writing a one to a flag clears it.
	assign wr_now = (state == ST_WRITE) && HREADY;

	always_comb begin
		clr0 = 16'h0000;
		clr1 = 16'h0000;
		if (wr_now && addr_q == `IFSB_OFS_FLAGS0) begin
			clr0 = HWDATA[15:0];
		end
		if (wr_now && addr_q == `IFSB_OFS_FLAGS1) begin
			clr1 = HWDATA[15:0];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			mask0 <= `IFSB_MASK_RST;
			mask1 <= `IFSB_MASK_RST;
		end else if (wr_now) begin
			if (addr_q == `IFSB_OFS_MASK0) begin
				mask0 <= HWDATA[15:0] & IMPL0;
			end
			if (addr_q == `IFSB_OFS_MASK1) begin
				mask1 <= HWDATA[15:0] & IMPL1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Request sources
	// ------------------------------------------------------------------------
	always_comb begin
		evt0 = 16'h0000;
		evt1 = 16'h0000;
		evt0[`IFSB_BIT_COMPARE1]   = COMPARE1_REQ;
		evt0[`IFSB_BIT_CAPTURE1]   = CAPTURE1_REQ;
		evt0[`IFSB_BIT_EXT_INPUT0] = EXT_INPUT0_REQ;
		evt1[`IFSB_BIT_TIMER_FIVE] = TIMER_FIVE_REQ;
		evt1[`IFSB_BIT_TIMER_FOUR] = TIMER_FOUR_REQ;
		evt1[`IFSB_BIT_COMPARE4]   = COMPARE4_REQ;
		evt1[`IFSB_BIT_COMPARE3]   = COMPARE3_REQ;
		evt1[`IFSB_BIT_EXT_INPUT2] = EXT_INPUT2_REQ;
		evt1[`IFSB_BIT_SERIAL2_RX] = SERIAL2_RX_REQ;
		evt1[`IFSB_BIT_SERIAL2_TX] = SERIAL2_TX_REQ;
	end

	// ------------------------------------------------------------------------
	// Sticky flags
	// ------------------------------------------------------------------------
	// A request in the cycle of its clear keeps the flag set.
	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_flag
			if (IMPL0[i]) begin : g_f0
				always_ff @(posedge SYS_CLK) begin
					if (!RST_N) begin
						flags0[i] <= FLAGS_RST[i];
					end else begin
						flags0[i] <= (flags0[i] & ~clr0[i]) | evt0[i];
					end
				end
			end else begin : g_u0
				assign flags0[i] = 1'b0;
			end
			if (IMPL1[i]) begin : g_f1
				always_ff @(posedge SYS_CLK) begin
					if (!RST_N) begin
						flags1[i] <= FLAGS_RST[i];
					end else begin
						flags1[i] <= (flags1[i] & ~clr1[i]) | evt1[i];
					end
				end
			end else begin : g_u1
				assign flags1[i] = 1'b0;
			end
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Read data and interrupt
	// ------------------------------------------------------------------------
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (addr_q)
			`IFSB_OFS_FLAGS0: next_rdata = {16'h0000, flags0};
			`IFSB_OFS_FLAGS1: next_rdata = {16'h0000, flags1};
			`IFSB_OFS_MASK0:  next_rdata = {16'h0000, mask0};
			`IFSB_OFS_MASK1:  next_rdata = {16'h0000, mask1};
			default:          next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			HRDATA <= 32'h0000_0000;
		end else if (state == ST_READ_WAIT) begin
			HRDATA <= next_rdata;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |((flags0 & mask0) | (flags1 & mask1));
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	a_cmp1_flag_set: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		COMPARE1_REQ |=> flags0[`IFSB_BIT_COMPARE1] && ($past(flags0) & ~IMPL0) == 16'h0000)
		else $error("compare 1 request did not set its flag");

	a_cap1_flag_hold: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		(flags0[`IFSB_BIT_CAPTURE1] && !clr0[`IFSB_BIT_CAPTURE1])
		|=> flags0[`IFSB_BIT_CAPTURE1])
		else $error("capture 1 flag dropped without a clear");

	a_ext0_read_back: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		(state == ST_READ_WAIT && addr_q == `IFSB_OFS_FLAGS0)
		|=> HRDATA[`IFSB_BIT_EXT_INPUT0] == $past(flags0[`IFSB_BIT_EXT_INPUT0]) && HREADYOUT)
		else $error("external input 0 flag read back wrong");

	a_tmr5_flag_set: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		$rose(TIMER_FIVE_REQ) |=> $past(TIMER_FIVE_REQ) && flags1[`IFSB_BIT_TIMER_FIVE])
		else $error("timer five request did not set its flag");

	a_tmr4_clear: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		(clr1[`IFSB_BIT_TIMER_FOUR] && !TIMER_FOUR_REQ) |=> !flags1[`IFSB_BIT_TIMER_FOUR])
		else $error("timer four flag not cleared by a one written");

	a_cmp4_set_wins: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		(clr1[`IFSB_BIT_COMPARE4] && COMPARE4_REQ) |=> flags1[`IFSB_BIT_COMPARE4])
		else $error("compare 4 request lost to a clear");

	a_cmp3_read_back: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		(state == ST_READ_WAIT && addr_q == `IFSB_OFS_FLAGS1)
		|=> HRDATA[`IFSB_BIT_COMPARE3] == $past(flags1[`IFSB_BIT_COMPARE3])
		&& HRDATA[8:0] == 9'h000 && HRDATA[31:16] == 16'h0000)
		else $error("compare 3 flag read back wrong");

	a_reset_clears: assert property (
		@(posedge SYS_CLK)
		!RST_N |=> flags0 == 16'h0000 && flags1 == 16'h0000 && !IRQ && HREADYOUT)
		else $error("flags not clear after reset");

	a_irq_follows: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		##1 IRQ == $past(|((flags0 & mask0) | (flags1 & mask1))))
		else $error("interrupt output does not follow masked flags");

	a_read_wait_one: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		!HREADYOUT |=> HREADYOUT)
		else $error("read wait state lasted more than one cycle");

	a_flags0_upper_zero: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		(state == ST_READ_WAIT && addr_q == `IFSB_OFS_FLAGS0)
		|=> HRDATA[31:3] == 29'h0)
		else $error("unimplemented bits of flag register 0 read nonzero");

	a_cmp1_clear: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		(clr0[`IFSB_BIT_COMPARE1] && !COMPARE1_REQ) |=> !flags0[`IFSB_BIT_COMPARE1])
		else $error("compare 1 flag not cleared by a one written");

	a_write_no_wait: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		state == ST_WRITE |-> HREADYOUT)
		else $error("write data phase was stretched");

endmodule : ifsb_top

// ===== bench/ifsb_src_model.sv
// Peripheral request source model for the interrupt flag status bank.
module ifsb_src_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       go,
	input  wire logic [9:0] sel,
	output logic      [9:0] req
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pulses last one cycle, so only the flag can remember the event.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			req <= 10'h000;
		end else begin
			req <= go ? sel : 10'h000;
		end
	end
endmodule : ifsb_src_model

// ===== bench/test_interrupt_flag_status_bank.sv
// Self-checking testbench of the interrupt flag status bank.
`include "ifsb_cfg.svh"

module test_interrupt_flag_status_bank;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk, rst_n, hsel, hwrite, hreadyout, hresp, irq, go;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [9:0]  sel, req;
	int          errors, num_checks, cyc;

	localparam logic [31:0] F0 = {24'h00, `IFSB_OFS_FLAGS0};
	localparam logic [31:0] F1 = {24'h00, `IFSB_OFS_FLAGS1};
	localparam logic [31:0] M0 = {24'h00, `IFSB_OFS_MASK0};
	localparam logic [31:0] M1 = {24'h00, `IFSB_OFS_MASK1};

	ifsb_src_model src_u (.clk(sys_clk), .rst_n(rst_n), .go(go), .sel(sel), .req(req));

	ifsb_top dut_u (
		.SYS_CLK(sys_clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.EXT_INPUT0_REQ(req[0]), .CAPTURE1_REQ(req[1]), .COMPARE1_REQ(req[2]),
		.COMPARE3_REQ(req[3]), .COMPARE4_REQ(req[4]), .TIMER_FOUR_REQ(req[5]),
		.TIMER_FIVE_REQ(req[6]), .EXT_INPUT2_REQ(req[7]), .SERIAL2_RX_REQ(req[8]),
		.SERIAL2_TX_REQ(req[9]), .IRQ(irq)
	);

	// ------------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// A single word transfer; each phase is held until ready is seen high.
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
			output logic [31:0] rd);
		@(posedge sys_clk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= a;
		hwrite <= w;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask : wr

	task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(a, 1'b0, 32'h0, r);
		chk(r, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask : rdc

	task automatic pulse(input logic [9:0] v);
		@(posedge sys_clk);
		go  <= 1'b1;
		sel <= v;
		@(posedge sys_clk);
		go  <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask : pulse

	// ------------------------------------------------------------------------
	// Clock, timeout and test sequence
	// ------------------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			end_of_test();
		end
	end

	initial begin
		logic [9:0] v;
		{rst_n, hsel, hwrite, go, htrans, sel} = '0;
		{haddr, hwdata} = '0;
		{errors, num_checks, cyc} = '0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		rdc(F0, 32'h0);
		rdc(F1, 32'h0);
		chk({31'h0, irq}, 32'h0);
		for (int i = 0; i < 10; i++) begin
			v = 10'h001 << i;
			pulse(v);
			wr(F0, 32'h0);
			wr(F1, 32'h0);
			rdc(F0, {29'h0, v[2:0]});
			rdc(F1, {16'h0, v[9:3], 9'h000});
			chk({31'h0, irq}, 32'h0);
			wr(F0, 32'hffffffff);
			wr(F1, 32'hffffffff);
			rdc(F0, 32'h0);
			rdc(F1, 32'h0);
		end
		wr(32'h10, 32'hffffffff);
		rdc(32'h10, 32'h0);
		// A request in the cycle of its clear must keep the flag set.
		pulse(10'h010);
		fork
			wr(F1, 32'h0000_0400);
			pulse(10'h010);
		join
		rdc(F1, 32'h0000_0400);
		wr(F1, 32'h0000_0400);
		rdc(F1, 32'h0);
		wr(M0, 32'hffffffff);
		wr(M1, 32'hffffffff);
		rdc(M0, 32'h00000007);
		rdc(M1, 32'h0000fe00);
		wr(M0, 32'h0);
		wr(M1, 32'h00001000);
		pulse(10'h040);
		@(posedge sys_clk);
		chk({31'h0, irq}, 32'h1);
		wr(M1, 32'h0);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		wr(M1, 32'h00001000);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h1);
		wr(F1, 32'h00001000);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		rdc(F1, 32'h0);
		pulse(10'h3ff);
		wr(M0, 32'hffffffff);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rdc(F0, 32'h0);
		rdc(F1, 32'h0);
		rdc(M0, 32'h0);
		chk({31'h0, irq}, 32'h0);
		end_of_test();
	end
endmodule : test_interrupt_flag_status_bank
